// ==== rtl/mci_interp.sv ====
// Single-axis motion command interpreter: receives nine-byte command frames,
// executes them or stores them as a program, runs stored programs, replies.
// Assumes a byte-wide receive stream and a valid/ready transmit sink on CLK.
//
// Summary of operation
// - Host is sole master; the device only answers commands it receives.
// - Each command is fully executed before its single reply starts.
// - Line is driven only while a reply is sent; never unsolicited.
// - Each command is decoded and its setup, reads and writes carried out.
// - Parameter 4 holds the positioning speed limit, readable and writable.
// - Parameter 5 holds ramp acceleration, also used in velocity mode.
// - Parameter 6 sets run current, 0 to 255 meaning 0 to full.
// - Parameter 7 sets hold current on the same scale.
// - Rotate-left starts continuous rotation at the commanded speed.
// - Motor halt stops the rotating motor.
// - Stored programs run without host, including jumps, compares, calculations.
// - Direct-mode commands use the binary encoding only.
// - Frame: address, command, type, motor, four value bytes MSB first, checksum.
// - Checksum is the 8-bit sum of all preceding bytes, both directions.
// - Reply: reply address, module address, status, command, value, checksum.
// - Status codes report stored, bad checksum, command, type, value, lock, unavailable.
`timescale 1ns/100ps
module mci_interp
	import mci_pkg::*;
#(
	parameter logic [7:0] MODULE_ADDR = 8'h01,
	parameter logic [7:0] REPLY_ADDR  = 8'h02,
	parameter int         PROG_DEPTH  = 64
)
(
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        TX_READY,
	output logic             TX_VALID,
	output logic [7:0]       TX_DATA,
	output logic             TX_ENABLE,
	output logic             MOTOR_RUN,
	output logic             MOTOR_DIR,
	output logic [10:0]      MOTOR_SPEED,
	output logic [10:0]      RAMP_ACCEL,
	output logic [7:0]       COIL_CURRENT,
	output logic [31:0]      MOVE_TARGET,
	output logic             MOVE_START,
	output logic             PROG_ACTIVE,
	output logic             STORE_ACTIVE
);

	localparam int PW = $clog2(PROG_DEPTH);
	localparam logic [PW-1:0] PC_LAST = PW'(PROG_DEPTH - 1);

	mci_state_t  state_q;
	logic [3:0]  rx_idx_q;
	logic [7:0]  rx_buf_q [8];
	logic [7:0]  rx_sum_q;
	logic        cks_ok_q;

	logic [55:0] prog_mem [PROG_DEPTH];
	logic [55:0] pm_word;
	logic [PW-1:0] pc_q;
	logic [PW-1:0] wr_ptr_q;
	logic        run_prog_q;
	logic        store_mode_q;
	logic [31:0] accu_q;
	logic        cmp_eq_q;
	logic        cmp_lt_q;

	logic [10:0] speed_lim_q;
	logic [10:0] accel_lim_q;
	logic [7:0]  run_cur_q;
	logic [7:0]  hold_cur_q;

	logic        src_host;
	logic        ex_go;
	logic [7:0]  ex_cmd;
	logic [7:0]  ex_type;
	logic [7:0]  ex_mot;
	logic [31:0] ex_val;
	logic [7:0]  ex_status;
	logic [31:0] ex_rval;
	logic        do_rotate;
	logic        do_halt;
	logic        do_move;
	logic        do_sap;
	logic        do_calc;
	logic        do_comp;
	logic        do_jump;
	logic        do_end;
	logic        do_run;
	logic        do_store;
	logic        do_enter;
	logic        do_exit;
	logic        cond_true;
	logic        tx_done;

	// Frame reception
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rx_idx_q <= 4'h0;
			rx_sum_q <= 8'h00;
			cks_ok_q <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				rx_buf_q[i] <= 8'h00;
			end
		end else if (RX_VALID && state_q == MCI_RECV) begin
			if (rx_idx_q == FRAME_LAST_IDX) begin
				cks_ok_q <= (RX_DATA == rx_sum_q);
				rx_idx_q <= 4'h0;
				rx_sum_q <= 8'h00;
			end else begin
				rx_buf_q[rx_idx_q[2:0]] <= RX_DATA;
				rx_sum_q <= rx_sum_q + RX_DATA;
				rx_idx_q <= rx_idx_q + 4'h1;
			end
		end
	end

	// Sequencing; frames for other nodes are dropped without a reply
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q <= MCI_RECV;
		end else begin
			case (state_q)
				MCI_RECV: begin
					if (RX_VALID && rx_idx_q == FRAME_LAST_IDX && rx_buf_q[0] == MODULE_ADDR) begin
						state_q <= MCI_EXEC;
					end
				end
				MCI_EXEC: state_q <= MCI_REPLY;
				MCI_REPLY: begin
					if (tx_done) begin
						state_q <= MCI_RECV;
					end
				end
				default: state_q <= MCI_RECV;
			endcase
		end
	end

	assign pm_word  = prog_mem[pc_q];
	assign src_host = (state_q == MCI_EXEC);
	// Program steps yield to a host command so its reply is never delayed
	assign ex_go    = src_host || (run_prog_q && state_q != MCI_EXEC);

	always_comb begin
		case (ex_type)
			JC_EQ:   cond_true = cmp_eq_q;
			JC_NE:   cond_true = !cmp_eq_q;
			JC_GT:   cond_true = !cmp_eq_q && !cmp_lt_q;
			JC_GE:   cond_true = !cmp_lt_q;
			JC_LT:   cond_true = cmp_lt_q;
			JC_LE:   cond_true = cmp_lt_q || cmp_eq_q;
			default: cond_true = 1'b0;
		endcase
	end

	// Command decode and outcome
	always_comb begin
		ex_cmd    = src_host ? rx_buf_q[1] : pm_word[55:48];
		ex_type   = src_host ? rx_buf_q[2] : pm_word[47:40];
		ex_mot    = src_host ? rx_buf_q[3] : pm_word[39:32];
		ex_val    = src_host ? {rx_buf_q[4], rx_buf_q[5], rx_buf_q[6], rx_buf_q[7]}
		                     : pm_word[31:0];
		ex_status = STS_OK;
		ex_rval   = ex_val;
		do_rotate = 1'b0;
		do_halt   = 1'b0;
		do_move   = 1'b0;
		do_sap    = 1'b0;
		do_calc   = 1'b0;
		do_comp   = 1'b0;
		do_jump   = 1'b0;
		do_end    = 1'b0;
		do_run    = 1'b0;
		do_store  = 1'b0;
		do_enter  = 1'b0;
		do_exit   = 1'b0;
		if (src_host && !cks_ok_q) begin
			ex_status = STS_BAD_CKSUM;
		end else if (src_host && store_mode_q && ex_cmd != STORE_EXIT_CMD) begin
			do_store  = 1'b1;
			ex_status = STS_STORED;
		end else begin
			case (ex_cmd)
				ROTATE_RIGHT_CMD, ROTATE_LEFT_CMD: begin
					if (ex_mot != 8'h00 || ex_val > RAMP_MAX) begin
						ex_status = STS_BAD_VALUE;
					end else begin
						do_rotate = 1'b1;
					end
				end
				MOTOR_HALT_CMD: begin
					if (ex_mot != 8'h00) begin
						ex_status = STS_BAD_VALUE;
					end else begin
						do_halt = 1'b1;
					end
				end
				MOVE_TO_POSITION_CMD: begin
					if (ex_type != 8'h00) begin
						ex_status = STS_BAD_TYPE;
					end else if (ex_mot != 8'h00) begin
						ex_status = STS_BAD_VALUE;
					end else begin
						do_move = 1'b1;
					end
				end
				SET_AXIS_PARAM_CMD: begin
					if (ex_type < AP_SPEED_LIMIT || ex_type > AP_HOLD_CURRENT) begin
						ex_status = STS_BAD_TYPE;
					end else if (ex_mot != 8'h00) begin
						ex_status = STS_BAD_VALUE;
					end else if (ex_type <= AP_ACCEL_LIMIT
					             && (ex_val < RAMP_MIN || ex_val > RAMP_MAX)) begin
						ex_status = STS_BAD_VALUE;
					end else if (ex_type >= AP_RUN_CURRENT && ex_val > CURRENT_MAX) begin
						ex_status = STS_BAD_VALUE;
					end else begin
						do_sap = 1'b1;
					end
				end
				GET_AXIS_PARAM_CMD: begin
					case (ex_type)
						AP_SPEED_LIMIT:  ex_rval = {21'h0, speed_lim_q};
						AP_ACCEL_LIMIT:  ex_rval = {21'h0, accel_lim_q};
						AP_RUN_CURRENT:  ex_rval = {24'h0, run_cur_q};
						AP_HOLD_CURRENT: ex_rval = {24'h0, hold_cur_q};
						default:         ex_status = STS_BAD_TYPE;
					endcase
					if (ex_mot != 8'h00) begin
						ex_status = STS_BAD_VALUE;
					end
				end
				CALCULATE_CMD, COMPARE_CMD, COND_JUMP_CMD, UNCONDITIONAL_JUMP_CMD,
				PROGRAM_END_CMD: begin
					if (src_host) begin
						ex_status = STS_UNAVAIL;
					end else if (ex_cmd == CALCULATE_CMD) begin
						if (ex_type > CALC_LOAD) begin
							ex_status = STS_BAD_TYPE;
						end else begin
							do_calc = 1'b1;
						end
					end else if (ex_cmd == COMPARE_CMD) begin
						do_comp = 1'b1;
					end else if (ex_cmd == PROGRAM_END_CMD) begin
						do_end = 1'b1;
					end else if (ex_val >= 32'(PROG_DEPTH)) begin
						ex_status = STS_BAD_VALUE;
					end else if (ex_cmd == UNCONDITIONAL_JUMP_CMD) begin
						do_jump = 1'b1;
					end else if (ex_type > JC_LE) begin
						ex_status = STS_BAD_TYPE;
					end else begin
						do_jump = cond_true;
					end
				end
				APP_STOP_CMD, APP_RUN_CMD, STORE_ENTER_CMD, STORE_EXIT_CMD: begin
					if (!src_host) begin
						ex_status = STS_UNAVAIL;
					end else if (ex_cmd == APP_STOP_CMD) begin
						do_end = 1'b1;
					end else if (ex_cmd == STORE_EXIT_CMD) begin
						do_exit = 1'b1;
					end else if (ex_cmd == STORE_ENTER_CMD && run_prog_q) begin
						ex_status = STS_LOCKED;
					end else if (ex_cmd == STORE_ENTER_CMD) begin
						do_enter = 1'b1;
					end else if (ex_val >= 32'(PROG_DEPTH)) begin
						ex_status = STS_BAD_VALUE;
					end else begin
						do_run = 1'b1;
					end
				end
				default: ex_status = STS_BAD_CMD;
			endcase
		end
	end

	// Axis parameters
	always_ff @(posedge CLK) begin
		if (SRST) begin
			speed_lim_q <= SPEED_LIMIT_RST;
			accel_lim_q <= ACCEL_LIMIT_RST;
			run_cur_q   <= RUN_CURRENT_RST;
			hold_cur_q  <= HOLD_CURRENT_RST;
		end else if (ex_go && do_sap) begin
			case (ex_type)
				AP_SPEED_LIMIT: speed_lim_q <= ex_val[10:0];
				AP_ACCEL_LIMIT: accel_lim_q <= ex_val[10:0];
				AP_RUN_CURRENT: run_cur_q   <= ex_val[7:0];
				default:        hold_cur_q  <= ex_val[7:0];
			endcase
		end
	end

	// Motion outputs
	always_ff @(posedge CLK) begin
		if (SRST) begin
			MOTOR_RUN    <= 1'b0;
			MOTOR_DIR    <= 1'b0;
			MOTOR_SPEED  <= 11'h000;
			MOVE_TARGET  <= 32'h0;
			MOVE_START   <= 1'b0;
			RAMP_ACCEL   <= ACCEL_LIMIT_RST;
			COIL_CURRENT <= HOLD_CURRENT_RST;
		end else begin
			MOVE_START   <= ex_go && do_move;
			RAMP_ACCEL   <= accel_lim_q;
			// Standby current lets the motor cool while stationary
			COIL_CURRENT <= MOTOR_RUN ? run_cur_q : hold_cur_q;
			if (ex_go && do_rotate) begin
				MOTOR_RUN   <= 1'b1;
				MOTOR_DIR   <= (ex_cmd == ROTATE_LEFT_CMD);
				MOTOR_SPEED <= ex_val[10:0];
			end else if (ex_go && do_halt) begin
				MOTOR_RUN   <= 1'b0;
			end else if (ex_go && do_move) begin
				MOTOR_SPEED <= speed_lim_q;
				MOVE_TARGET <= ex_val;
			end
		end
	end

	// Program store and execution
	always_ff @(posedge CLK) begin
		if (ex_go && do_store) begin
			prog_mem[wr_ptr_q] <= {ex_cmd, ex_type, ex_mot, ex_val};
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			store_mode_q <= 1'b0;
			wr_ptr_q     <= '0;
			run_prog_q   <= 1'b0;
			pc_q         <= '0;
		end else begin
			if (ex_go && do_enter) begin
				store_mode_q <= 1'b1;
				wr_ptr_q     <= '0;
			end else if (ex_go && do_exit) begin
				store_mode_q <= 1'b0;
			end else if (ex_go && do_store) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (src_host) begin
				if (do_run) begin
					run_prog_q <= 1'b1;
					pc_q       <= ex_val[PW-1:0];
				end else if (do_end) begin
					run_prog_q <= 1'b0;
				end
			end else if (ex_go) begin
				// A failing step ends the program instead of running on blindly
				if (do_end || ex_status != STS_OK || (!do_jump && pc_q == PC_LAST)) begin
					run_prog_q <= 1'b0;
				end else if (do_jump) begin
					pc_q <= ex_val[PW-1:0];
				end else begin
					pc_q <= pc_q + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			accu_q   <= 32'h0;
			cmp_eq_q <= 1'b0;
			cmp_lt_q <= 1'b0;
		end else if (ex_go && do_calc) begin
			case (ex_type)
				CALC_ADD: accu_q <= accu_q + ex_val;
				CALC_SUB: accu_q <= accu_q - ex_val;
				CALC_AND: accu_q <= accu_q & ex_val;
				CALC_OR:  accu_q <= accu_q | ex_val;
				CALC_XOR: accu_q <= accu_q ^ ex_val;
				default:  accu_q <= ex_val;
			endcase
		end else if (ex_go && do_comp) begin
			cmp_eq_q <= (accu_q == ex_val);
			cmp_lt_q <= ($signed(accu_q) < $signed(ex_val));
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			PROG_ACTIVE  <= 1'b0;
			STORE_ACTIVE <= 1'b0;
		end else begin
			PROG_ACTIVE  <= run_prog_q;
			STORE_ACTIVE <= store_mode_q;
		end
	end

	// Reply is launched in the execute cycle, after all effects are decided
	mci_reply_tx u_reply (
		.clk       (CLK),
		.srst      (SRST),
		.start     (src_host),
		.payload   ({REPLY_ADDR, MODULE_ADDR, ex_status, ex_cmd, ex_rval}),
		.tx_ready  (TX_READY),
		.tx_valid  (TX_VALID),
		.tx_data   (TX_DATA),
		.tx_enable (TX_ENABLE),
		.done      (tx_done)
	);

endmodule // mci_interp

// ==== rtl/mci_pkg.sv ====
// Shared constants for the motion command interpreter: frame layout,
// command and status codes, axis parameter numbers, ranges and reset values.
// Assumes nothing of its surroundings.
package mci_pkg;

	// Frame layout: eight payload bytes, then the checksum byte
	localparam logic [3:0]  FRAME_LAST_IDX    = 4'h8;
	localparam logic [3:0]  FRAME_DONE_IDX    = 4'h9;

	// Command numbers
	localparam logic [7:0]  ROTATE_RIGHT_CMD   = 8'h01;
	localparam logic [7:0]  ROTATE_LEFT_CMD    = 8'h02;
	localparam logic [7:0]  MOTOR_HALT_CMD     = 8'h03;
	localparam logic [7:0]  MOVE_TO_POSITION_CMD = 8'h04;
	localparam logic [7:0]  SET_AXIS_PARAM_CMD = 8'h05;
	localparam logic [7:0]  GET_AXIS_PARAM_CMD = 8'h06;
	localparam logic [7:0]  CALCULATE_CMD      = 8'h13;
	localparam logic [7:0]  COMPARE_CMD        = 8'h14;
	localparam logic [7:0]  COND_JUMP_CMD      = 8'h15;
	localparam logic [7:0]  UNCONDITIONAL_JUMP_CMD = 8'h16;
	localparam logic [7:0]  PROGRAM_END_CMD    = 8'h1C;
	localparam logic [7:0]  APP_STOP_CMD       = 8'h80;
	localparam logic [7:0]  APP_RUN_CMD        = 8'h81;
	localparam logic [7:0]  STORE_ENTER_CMD    = 8'h84;
	localparam logic [7:0]  STORE_EXIT_CMD     = 8'h85;

	// Reply status codes
	localparam logic [7:0]  STS_OK             = 8'h64;
	localparam logic [7:0]  STS_STORED         = 8'h65;
	localparam logic [7:0]  STS_BAD_CKSUM      = 8'h01;
	localparam logic [7:0]  STS_BAD_CMD        = 8'h02;
	localparam logic [7:0]  STS_BAD_TYPE       = 8'h03;
	localparam logic [7:0]  STS_BAD_VALUE      = 8'h04;
	localparam logic [7:0]  STS_LOCKED         = 8'h05;
	localparam logic [7:0]  STS_UNAVAIL        = 8'h06;

	// Axis parameter numbers
	localparam logic [7:0]  AP_SPEED_LIMIT     = 8'h04;
	localparam logic [7:0]  AP_ACCEL_LIMIT     = 8'h05;
	localparam logic [7:0]  AP_RUN_CURRENT     = 8'h06;
	localparam logic [7:0]  AP_HOLD_CURRENT    = 8'h07;

	// Value ranges
	localparam logic [31:0] RAMP_MIN           = 32'h0000_0001;
	localparam logic [31:0] RAMP_MAX           = 32'h0000_07FF;
	localparam logic [31:0] CURRENT_MAX        = 32'h0000_00FF;

	// Values after reset
	localparam logic [10:0] SPEED_LIMIT_RST    = 11'h3E8;
	localparam logic [10:0] ACCEL_LIMIT_RST    = 11'h1F4;
	localparam logic [7:0]  RUN_CURRENT_RST    = 8'h80;
	localparam logic [7:0]  HOLD_CURRENT_RST   = 8'h20;

	// Calculation operations (type field)
	localparam logic [7:0]  CALC_ADD           = 8'h00;
	localparam logic [7:0]  CALC_SUB           = 8'h01;
	localparam logic [7:0]  CALC_AND           = 8'h02;
	localparam logic [7:0]  CALC_OR            = 8'h03;
	localparam logic [7:0]  CALC_XOR           = 8'h04;
	localparam logic [7:0]  CALC_LOAD          = 8'h05;

	// Jump conditions (type field), after a compare
	localparam logic [7:0]  JC_EQ              = 8'h00;
	localparam logic [7:0]  JC_NE              = 8'h01;
	localparam logic [7:0]  JC_GT              = 8'h02;
	localparam logic [7:0]  JC_GE              = 8'h03;
	localparam logic [7:0]  JC_LT              = 8'h04;
	localparam logic [7:0]  JC_LE              = 8'h05;

	typedef enum logic [1:0] {
		MCI_RECV  = 2'b00,
		MCI_EXEC  = 2'b01,
		MCI_REPLY = 2'b10
	} mci_state_t;

endpackage

// ==== rtl/mci_reply_tx.sv ====
// Reply serialiser: sends eight payload bytes MSB first, then their 8-bit sum.
// Assumes a byte sink with valid/ready handshake on the same clock.
`timescale 1ns/100ps
module mci_reply_tx
	import mci_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        start,
	input  wire logic [63:0] payload,
	input  wire logic        tx_ready,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_enable,
	output logic             done
);

	logic [63:0] buf_q;
	logic [3:0]  idx_q;
	logic [7:0]  sum_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			buf_q     <= 64'h0;
			idx_q     <= 4'h0;
			sum_q     <= 8'h00;
			tx_valid  <= 1'b0;
			tx_data   <= 8'h00;
			tx_enable <= 1'b0;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !tx_enable) begin
				// Drive the line only while a reply is in flight
				tx_enable <= 1'b1;
				tx_valid  <= 1'b1;
				tx_data   <= payload[63:56];
				sum_q     <= payload[63:56];
				buf_q     <= {payload[55:0], 8'h00};
				idx_q     <= 4'h1;
			end else if (tx_valid && tx_ready) begin
				if (idx_q == FRAME_DONE_IDX) begin
					tx_valid  <= 1'b0;
					tx_enable <= 1'b0;
					done      <= 1'b1;
				end else if (idx_q == FRAME_LAST_IDX) begin
					tx_data <= sum_q;
					idx_q   <= FRAME_DONE_IDX;
				end else begin
					tx_data <= buf_q[63:56];
					sum_q   <= sum_q + buf_q[63:56];
					buf_q   <= {buf_q[55:0], 8'h00};
					idx_q   <= idx_q + 4'h1;
				end
			end
		end
	end

endmodule // mci_reply_tx

// ==== bench/mci_interp_assertions.sv ====
// Reply and output checker for the command interpreter.
// Sees only the top module's ports; attached by the bind below.
`timescale 1ns/100ps
module mci_interp_checker #(
	parameter logic [7:0] MODULE_ADDR = 8'h01,
	parameter logic [7:0] REPLY_ADDR  = 8'h02
)
(
	input wire logic        CLK,
	input wire logic        SRST,
	input wire logic        RX_VALID,
	input wire logic        TX_READY,
	input wire logic        TX_VALID,
	input wire logic [7:0]  TX_DATA,
	input wire logic        TX_ENABLE,
	input wire logic        MOTOR_RUN,
	input wire logic [10:0] RAMP_ACCEL,
	input wire logic [7:0]  COIL_CURRENT,
	input wire logic        MOVE_START
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	logic [3:0] acc_q;
	logic [7:0] sum_q;
	logic [7:0] last_q;

	// Cleared between replies so a short reply cannot borrow a count
	always_ff @(posedge CLK) begin
		if (SRST || !TX_ENABLE) begin
			acc_q <= 4'h0;
			sum_q <= 8'h00;
		end else if (TX_VALID && TX_READY) begin
			acc_q <= acc_q + 4'h1;
			if (acc_q < 4'h8)
				sum_q <= sum_q + TX_DATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (TX_VALID && TX_READY)
			last_q <= TX_DATA;
	end

	sequence s_reply_open;
		TX_ENABLE && TX_VALID && TX_DATA == REPLY_ADDR;
	endsequence

	sequence s_second_byte;
		TX_VALID && TX_DATA == MODULE_ADDR;
	endsequence

	a_reset_values: assert property ($fell(SRST) |-> RAMP_ACCEL == 11'h1F4 // RESET
		&& COIL_CURRENT == 8'h20 && !TX_ENABLE && !MOTOR_RUN)
		else $error("outputs wrong after reset");
	a_rx_to_reply: assert property ($rose(TX_ENABLE) |-> $past(RX_VALID, 2))
		else $error("reply not two cycles after last byte");
	a_reply_header: assert property ($rose(TX_ENABLE) && TX_READY
		|-> s_reply_open ##1 s_second_byte)
		else $error("reply header wrong");
	a_valid_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("reply byte dropped before accept");
	a_no_unsolicited: assert property (TX_VALID |-> TX_ENABLE)
		else $error("byte offered with driver off");
	a_enable_ends: assert property ($fell(TX_ENABLE) |-> $past(TX_VALID) && $past(TX_READY))
		else $error("driver released without accept");
	a_reply_length: assert property ($fell(TX_ENABLE) |-> acc_q == 4'h9)
		else $error("reply not nine bytes");
	a_reply_cksum: assert property ($fell(TX_ENABLE) |-> last_q == sum_q)
		else $error("reply checksum wrong");
	a_move_pulse: assert property (MOVE_START |=> !MOVE_START)
		else $error("move start longer than one cycle");
	a_accel_legal: assert property (RAMP_ACCEL != 11'h000)
		else $error("acceleration limit zero");
endmodule // mci_interp_checker

bind mci_interp mci_interp_checker #(.MODULE_ADDR(MODULE_ADDR), .REPLY_ADDR(REPLY_ADDR)) chk_i (
	.CLK(CLK), .SRST(SRST), .RX_VALID(RX_VALID), .TX_READY(TX_READY),
	.TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_ENABLE(TX_ENABLE),
	.MOTOR_RUN(MOTOR_RUN), .RAMP_ACCEL(RAMP_ACCEL), .COIL_CURRENT(COIL_CURRENT),
	.MOVE_START(MOVE_START)
);

// ==== bench/mci_host_model.sv ====
// Host side of the command link: sends binary frames, collects replies.
// Assumes one clock shared with the interpreter; seeded by the bench.
`timescale 1ns/100ps
module mci_host_model (
	input  wire logic       clk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            tx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data
);
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'hA5;
		tx_ready = 1'b0;
	end

	// Host speaks only when the bench asks, one frame at a time
	task automatic xfer(input logic [63:0] pl, input logic bad, input int bound,
			output logic [71:0] rep, output logic got);
		logic [7:0] ck;
		int         n;
		int         t;
		ck  = 8'h00;
		rep = '0;
		n   = 0;
		t   = 0;
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_data  <= pl[i*8 +: 8];
			ck = ck + pl[i*8 +: 8];
		end
		@(posedge clk);
		rx_data <= bad ? ~ck : ck;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data  <= bad ? ck : ~ck;
		// Random stalls keep the reply side under pressure
		while (n < 9 && t < bound) begin
			@(posedge clk);
			t++;
			if (tx_valid && tx_ready) begin
				rep = {rep[63:0], tx_data};
				n++;
			end
			tx_ready <= (n < 9) && ($urandom_range(3) != 0);
		end
		got = (n == 9);
		repeat (2) @(posedge clk);
	endtask
endmodule // mci_host_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the command interpreter.
// Assumes the package constants and the host model beside it.
`timescale 1ns/100ps
module tb_top import mci_pkg::*;;
	localparam logic [7:0] MA = 8'h01;
	localparam logic [7:0] RA = 8'h02;
	logic        CLK, SRST, RX_VALID, TX_READY, TX_VALID, TX_ENABLE;
	logic [7:0]  RX_DATA, TX_DATA, COIL_CURRENT;
	logic        MOTOR_RUN, MOTOR_DIR, MOVE_START, PROG_ACTIVE, STORE_ACTIVE;
	logic [10:0] MOTOR_SPEED, RAMP_ACCEL;
	logic [31:0] MOVE_TARGET, v;
	logic [71:0] rep;
	logic        got;
	int          err_total, total_checks;
	int          moves = 0;
	always @(posedge CLK)
		if (MOVE_START)
			moves <= moves + 1;
	logic [7:0]  ap [4] = '{AP_SPEED_LIMIT, AP_ACCEL_LIMIT, AP_RUN_CURRENT, AP_HOLD_CURRENT};
	logic [31:0] lo [4] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
	logic [31:0] hi [4] = '{RAMP_MAX, RAMP_MAX, CURRENT_MAX, CURRENT_MAX};
	logic [31:0] cur [4] = '{32'h0000_03E8, 32'h0000_01F4, 32'h0000_0080, 32'h0000_0020};

	mci_host_model host (.clk(CLK), .rx_valid(RX_VALID), .rx_data(RX_DATA),
		.tx_ready(TX_READY), .tx_valid(TX_VALID), .tx_data(TX_DATA));

	mci_interp #(.MODULE_ADDR(MA), .REPLY_ADDR(RA), .PROG_DEPTH(64)) uut (
		.CLK(CLK), .SRST(SRST), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
		.TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
		.TX_ENABLE(TX_ENABLE), .MOTOR_RUN(MOTOR_RUN), .MOTOR_DIR(MOTOR_DIR),
		.MOTOR_SPEED(MOTOR_SPEED), .RAMP_ACCEL(RAMP_ACCEL), .COIL_CURRENT(COIL_CURRENT),
		.MOVE_TARGET(MOVE_TARGET), .MOVE_START(MOVE_START), .PROG_ACTIVE(PROG_ACTIVE),
		.STORE_ACTIVE(STORE_ACTIVE));

	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	function automatic logic [7:0] sum8(input logic [63:0] p);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++)
			s = s + p[i*8 +: 8];
		return s;
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic cmd(input logic [7:0] c, t, m, input logic [31:0] val, input logic bad,
			input logic [7:0] st, input logic [31:0] rv);
		host.xfer({MA, c, t, m, val}, bad, 400, rep, got);
		chk("reply seen", 32'h0000_0001, 32'(got));
		if (got !== 1'b1)
			test_done();
		chk("reply head", {RA, MA, st, c}, rep[71:40]);
		chk("reply value", rv, rep[39:8]);
		chk("reply sum", 32'(sum8({RA, MA, st, c, rv})), 32'(rep[7:0]));
	endtask

	task automatic store_step(input logic [7:0] c, t, input logic [31:0] val);
		cmd(c, t, 8'h00, val, 1'b0, STS_STORED, val);
	endtask

	initial begin
		SRST = 1'b1;
		err_total = 0;
		total_checks = 0;
		void'($urandom(48717));
		repeat (20) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		chk("accel", 32'h0000_01F4, 32'(RAMP_ACCEL)); // RESET
		chk("coil", 32'h0000_0020, 32'(COIL_CURRENT)); // RESET
		for (int i = 0; i < 4; i++) begin
			cmd(GET_AXIS_PARAM_CMD, ap[i], 8'h00, 32'h0, 1'b0, STS_OK, cur[i]);
			cmd(SET_AXIS_PARAM_CMD, ap[i], 8'h00, hi[i], 1'b0, STS_OK, hi[i]);
			v = lo[i] + $urandom_range(hi[i] - lo[i]);
			cmd(SET_AXIS_PARAM_CMD, ap[i], 8'h00, v, 1'b0, STS_OK, v);
			cur[i] = v;
			cmd(SET_AXIS_PARAM_CMD, ap[i], 8'h00, hi[i] + 32'h1, 1'b0, STS_BAD_VALUE, hi[i] + 32'h1);
			cmd(SET_AXIS_PARAM_CMD, ap[i], 8'h00, lo[i] - 32'h1, 1'b0, STS_BAD_VALUE, lo[i] - 32'h1);
			cmd(SET_AXIS_PARAM_CMD, ap[i], 8'h01, lo[i], 1'b0, STS_BAD_VALUE, lo[i]);
			cmd(GET_AXIS_PARAM_CMD, ap[i], 8'h00, 32'h0, 1'b0, STS_OK, cur[i]);
		end
		chk("accel", cur[1], 32'(RAMP_ACCEL));
		chk("hold", cur[3], 32'(COIL_CURRENT));
		v = 32'($urandom_range(2047));
		cmd(ROTATE_LEFT_CMD, 8'h00, 8'h00, v, 1'b0, STS_OK, v);
		chk("run", 32'h0000_0001, 32'(MOTOR_RUN));
		chk("dir", 32'h0000_0001, 32'(MOTOR_DIR));
		chk("speed", v, 32'(MOTOR_SPEED));
		chk("run coil", cur[2], 32'(COIL_CURRENT));
		cmd(ROTATE_RIGHT_CMD, 8'h00, 8'h00, 32'h7FF, 1'b0, STS_OK, 32'h7FF);
		chk("dir", 32'h0000_0000, 32'(MOTOR_DIR));
		cmd(MOTOR_HALT_CMD, 8'h00, 8'h00, 32'h0, 1'b0, STS_OK, 32'h0);
		chk("run", 32'h0000_0000, 32'(MOTOR_RUN));
		chk("hold", cur[3], 32'(COIL_CURRENT));
		v = $urandom();
		cmd(MOVE_TO_POSITION_CMD, 8'h00, 8'h00, v, 1'b0, STS_OK, v);
		chk("target", v, MOVE_TARGET);
		chk("move speed", cur[0], 32'(MOTOR_SPEED));
		chk("move pulses", 32'h0000_0001, 32'(moves));
		cmd(SET_AXIS_PARAM_CMD, AP_HOLD_CURRENT, 8'h00, 32'h11, 1'b1, STS_BAD_CKSUM, 32'h11);
		cmd(GET_AXIS_PARAM_CMD, AP_HOLD_CURRENT, 8'h00, 32'h0, 1'b0, STS_OK, cur[3]);
		cmd(8'h77, 8'h00, 8'h00, 32'h0, 1'b0, STS_BAD_CMD, 32'h0);
		cmd(SET_AXIS_PARAM_CMD, 8'h09, 8'h00, 32'h1, 1'b0, STS_BAD_TYPE, 32'h1);
		cmd(PROGRAM_END_CMD, 8'h00, 8'h00, 32'h0, 1'b0, STS_UNAVAIL, 32'h0);
		// Calc and compare steer both jump senses; any wrong turn writes 0x44
		cmd(STORE_ENTER_CMD, 8'h00, 8'h00, 32'h0, 1'b0, STS_OK, 32'h0);
		chk("store", 32'h0000_0001, 32'(STORE_ACTIVE));
		store_step(CALCULATE_CMD, CALC_LOAD, 32'h30);
		store_step(CALCULATE_CMD, CALC_ADD, 32'h3);
		store_step(COMPARE_CMD, 8'h00, 32'h33);
		store_step(COND_JUMP_CMD, JC_NE, 32'h5);
		store_step(COND_JUMP_CMD, JC_EQ, 32'h7);
		store_step(SET_AXIS_PARAM_CMD, AP_HOLD_CURRENT, 32'h44);
		store_step(UNCONDITIONAL_JUMP_CMD, 8'h00, 32'h6);
		store_step(SET_AXIS_PARAM_CMD, AP_HOLD_CURRENT, 32'h33);
		store_step(UNCONDITIONAL_JUMP_CMD, 8'h00, 32'h8);
		cmd(STORE_EXIT_CMD, 8'h00, 8'h00, 32'h0, 1'b0, STS_OK, 32'h0);
		chk("store", 32'h0000_0000, 32'(STORE_ACTIVE));
		cmd(APP_RUN_CMD, 8'h00, 8'h00, 32'h0, 1'b0, STS_OK, 32'h0);
		chk("prog", 32'h0000_0001, 32'(PROG_ACTIVE));
		cmd(GET_AXIS_PARAM_CMD, AP_HOLD_CURRENT, 8'h00, 32'h0, 1'b0, STS_OK, 32'h33);
		cmd(STORE_ENTER_CMD, 8'h00, 8'h00, 32'h0, 1'b0, STS_LOCKED, 32'h0);
		cmd(APP_STOP_CMD, 8'h00, 8'h00, 32'h0, 1'b0, STS_OK, 32'h0);
		chk("prog", 32'h0000_0000, 32'(PROG_ACTIVE));
		host.xfer({8'h05, GET_AXIS_PARAM_CMD, AP_SPEED_LIMIT, 8'h00, 32'h0}, 1'b0, 40, rep, got);
		chk("silent", 32'h0000_0000, 32'(got));
		test_done();
	end
endmodule // tb_top
